/* hw/rft_pkg.sv */
package rft_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int BIT_RATE_BPS = 2400;
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
  localparam int SAMPLE_CYCLES = (BIT_CYCLES * 3) / 4;
  localparam int GAP_BITS = 8;
  localparam int GAP_CYCLES = GAP_BITS * BIT_CYCLES;
  localparam int DWELL_MS = 500;
  localparam int DWELL_CYCLES = (CLK_HZ / 1000) * DWELL_MS;
  localparam int COM_HZ = 64;
  localparam int COM_CYCLES = CLK_HZ / (2 * COM_HZ);
  // ==========================================================
  // Frame layout
  localparam int FRAME_BITS = 36;
  localparam int FIELD_BITS = 12;
  localparam int PAY_LSB = 12;
  localparam int POST_LSB = 24;
  localparam int COPIES = 4;
  localparam int STATE_BITS = 3;
  localparam logic [11:0] PREAMBLE = 12'ha5a;
  localparam logic [11:0] POSTAMBLE = 12'h3c3;
  typedef struct packed {logic [5:0] hi; logic [5:0] lo;} rft_payload_t;
  typedef struct packed {logic [7:0] hi; logic [7:0] lo;} rft_segs_t;
  // ==========================================================
  // Tables
  localparam logic [95:0] SYMBOLS = {6'h23, 6'h1c, 6'h34, 6'h32, 6'h2c, 6'h2a, 6'h29, 6'h26,
                                     6'h25, 6'h1a, 6'h19, 6'h16, 6'h15, 6'h13, 6'h0d, 6'h0b};
  localparam logic [127:0] SEGS = {8'h71, 8'h79, 8'h5e, 8'h39, 8'h7c, 8'h77, 8'h6f, 8'h7f,
                                   8'h07, 8'h7d, 8'h6d, 8'h66, 8'h4f, 8'h5b, 8'h06, 8'h3f};

  function automatic logic [5:0] nibble_to_symbol(input logic [3:0] n);
    return SYMBOLS[n*6 +: 6];
  endfunction : nibble_to_symbol

  function automatic logic [3:0] symbol_to_nibble_table(input logic [5:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (SYMBOLS[i*6 +: 6] == s) r = 4'(i);
    end
    return r;
  endfunction : symbol_to_nibble_table

  function automatic logic [7:0] nibble_to_segment_table(input logic [3:0] n);
    return SEGS[n*8 +: 8];
  endfunction : nibble_to_segment_table

  function automatic rft_payload_t state_payload(input logic [2:0] idx);
    rft_payload_t p;
    p.hi = nibble_to_symbol({1'b0, idx});
    p.lo = nibble_to_symbol({1'b1, idx});
    return p;
  endfunction : state_payload
endpackage : rft_pkg

/* hw/rft_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module rft_buf #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic wr_reg;
  logic rd_reg;
  logic [1:0] cnt_reg;
  wire push_w = in_valid && in_ready;
  wire pop_w = out_valid && out_ready;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_reg];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push_w) mem_reg[wr_reg] <= in_data;
      if (push_w) wr_reg <= !wr_reg;
      if (pop_w) rd_reg <= !rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push_w} - {1'b0, pop_w};
    end
  end
endmodule : rft_buf
`default_nettype wire

/* hw/rft_pacer.sv */
`timescale 1ns/1ps
`default_nettype none
module rft_pacer #(
  parameter int DWELL = 62_500_000,
  parameter int COM = 976_562
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Outputs
  output logic advance,
  output logic display_common_drive
);
  localparam int DW_W = $clog2(DWELL);
  localparam int CM_W = $clog2(COM);
  logic [DW_W-1:0] dw_reg;
  logic [CM_W-1:0] cm_reg;
  logic adv_reg;
  logic com_reg;
  wire dw_end_w = (dw_reg == DW_W'(DWELL - 1));
  wire cm_end_w = (cm_reg == CM_W'(COM - 1));

  assign advance = adv_reg;
  assign display_common_drive = com_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dw_reg <= '0;
      cm_reg <= '0;
      adv_reg <= 1'b0;
      com_reg <= 1'b0;
    end else begin
      dw_reg <= dw_end_w ? '0 : dw_reg + 1'b1;
      adv_reg <= dw_end_w;
      cm_reg <= cm_end_w ? '0 : cm_reg + 1'b1;
      if (cm_end_w) com_reg <= !com_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_advance_one_cycle: assert property (adv_reg |=> !adv_reg) else $error("advance longer than one cycle");
  a_common_toggle_time: assert property ($changed(com_reg) |-> $past(cm_end_w)) else $error("common moved off tick");
endmodule : rft_pacer
`default_nettype wire

/* hw/rft_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rft_top #(
  parameter int BIT_CYCLES = rft_pkg::BIT_CYCLES,
  parameter int SAMPLE_CYCLES = rft_pkg::SAMPLE_CYCLES,
  parameter int GAP_CYCLES = rft_pkg::GAP_CYCLES,
  parameter int DWELL_CYCLES = rft_pkg::DWELL_CYCLES,
  parameter int COM_CYCLES = rft_pkg::COM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Radio link
  input wire logic radio_rx_data,
  output logic radio_tx_data,
  output logic radio_tx_mode,
  output logic radio_rx_mode,
  // Display
  output logic display_common_drive,
  output logic [15:0] display_segments,
  output logic rx_accept
);
  // ==========================================================
  // Widths
  localparam int BT_W = $clog2(BIT_CYCLES);
  localparam int GP_W = $clog2(GAP_CYCLES + 1);
  localparam int FB = rft_pkg::FRAME_BITS;

  // ==========================================================
  // Pacing
  logic advance_w;
  rft_pacer #(
    .DWELL(DWELL_CYCLES),
    .COM(COM_CYCLES)
  ) u_pacer (
    .clk(clk),
    .rst_n(rst_n),
    .advance(advance_w),
    .display_common_drive(display_common_drive)
  );

  // ==========================================================
  // State sequencer
  logic [2:0] current_state_index_reg;
  logic [2:0] frame_repeat_counter_reg;
  logic [GP_W-1:0] frame_gap_counter_reg;
  logic buf_in_ready_w;
  rft_pkg::rft_payload_t state_payload_w;
  wire reps_left_w = (frame_repeat_counter_reg != 3'(rft_pkg::COPIES));
  wire gap_done_w = (frame_gap_counter_reg == '0);
  wire load_w = !advance_w && reps_left_w && gap_done_w && buf_in_ready_w;
  assign state_payload_w = rft_pkg::state_payload(current_state_index_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_state_index_reg <= 3'h0;
      frame_repeat_counter_reg <= 3'h0;
      frame_gap_counter_reg <= '0;
    end else if (advance_w) begin
      current_state_index_reg <= current_state_index_reg + 3'h1;
      frame_repeat_counter_reg <= 3'h0;
      frame_gap_counter_reg <= '0;
    end else if (load_w) begin
      frame_repeat_counter_reg <= frame_repeat_counter_reg + 3'h1;
      frame_gap_counter_reg <= GP_W'(GAP_CYCLES);
    end else if (!gap_done_w) begin
      frame_gap_counter_reg <= frame_gap_counter_reg - 1'b1;
    end
  end

  // ==========================================================
  // Frame buffer
  logic buf_out_valid_w;
  logic ser_ready_w;
  rft_pkg::rft_payload_t buf_out_w;
  rft_buf #(
    .W(rft_pkg::FIELD_BITS)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(load_w),
    .in_ready(buf_in_ready_w),
    .in_data(state_payload_w),
    .out_valid(buf_out_valid_w),
    .out_ready(ser_ready_w),
    .out_data(buf_out_w)
  );

  // ==========================================================
  // Serializer
  logic [FB-1:0] tx_shift_reg;
  logic [5:0] tx_bits_reg;
  logic [BT_W-1:0] tx_cnt_reg;
  logic tx_busy_reg;
  logic tx_mode_reg;
  wire pop_w = ser_ready_w && buf_out_valid_w;
  wire tx_tick_w = tx_busy_reg && (tx_cnt_reg == BT_W'(BIT_CYCLES - 1));
  wire tx_last_w = (tx_bits_reg == 6'(FB - 1));
  wire [FB-1:0] frame_w = {rft_pkg::POSTAMBLE, buf_out_w, rft_pkg::PREAMBLE};
  assign ser_ready_w = !tx_busy_reg;
  assign radio_tx_data = tx_shift_reg[0];
  assign radio_tx_mode = tx_mode_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg <= '0;
      tx_bits_reg <= 6'h00;
      tx_cnt_reg <= '0;
      tx_busy_reg <= 1'b0;
      tx_mode_reg <= 1'b1;
    end else if (pop_w) begin
      tx_shift_reg <= frame_w;
      tx_bits_reg <= 6'h00;
      tx_cnt_reg <= '0;
      tx_busy_reg <= 1'b1;
    end else if (tx_tick_w) begin
      tx_shift_reg <= {1'b0, tx_shift_reg[FB-1:1]};
      tx_bits_reg <= tx_bits_reg + 6'h01;
      tx_cnt_reg <= '0;
      tx_busy_reg <= !tx_last_w;
    end else if (tx_busy_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Receive sampling
  logic sync1_reg;
  logic sync2_reg;
  logic [2:0] sample_history_reg;
  logic [BT_W-1:0] rx_cnt_reg;
  logic rx_run_reg;
  logic rx_mode_reg;
  logic [FB-1:0] rx_shift_reg;
  wire edge_w = sample_history_reg[1] ^ sample_history_reg[0];
  wire rx_wrap_w = (rx_cnt_reg == BT_W'(BIT_CYCLES - 1));
  wire sample_w = rx_run_reg && !edge_w && (rx_cnt_reg == BT_W'(SAMPLE_CYCLES - 1));
  wire [FB-1:0] rx_next_w = {sample_history_reg[0], rx_shift_reg[FB-1:1]};
  wire post_w = sample_w && (rx_next_w[FB-1:rft_pkg::POST_LSB] == rft_pkg::POSTAMBLE);
  assign radio_rx_mode = rx_mode_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sample_history_reg <= 3'h0;
      rx_cnt_reg <= '0;
      rx_run_reg <= 1'b0;
      rx_mode_reg <= 1'b0;
    end else begin
      sync1_reg <= radio_rx_data;
      sync2_reg <= sync1_reg;
      sample_history_reg <= {sample_history_reg[1:0], sync2_reg};
      if (edge_w) begin
        rx_cnt_reg <= '0;
        rx_run_reg <= 1'b1;
      end else if (rx_run_reg) begin
        rx_cnt_reg <= rx_wrap_w ? '0 : rx_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Capture and vote
  rft_pkg::rft_payload_t holding_copy_reg [3];
  logic [1:0] copy_idx_reg;
  rft_pkg::rft_segs_t disp_reg;
  logic accept_reg;
  logic [15:0] seg_out_reg;
  rft_pkg::rft_payload_t new_w;
  rft_pkg::rft_payload_t pick_w;
  rft_pkg::rft_segs_t segs_w;
  assign new_w = rx_next_w[rft_pkg::PAY_LSB +: rft_pkg::FIELD_BITS];
  wire fourth_w = post_w && (copy_idx_reg == 2'h3);
  wire m01_w = (holding_copy_reg[0] == holding_copy_reg[1]);
  wire m02_w = (holding_copy_reg[0] == holding_copy_reg[2]);
  wire m03_w = (holding_copy_reg[0] == new_w);
  wire m12_w = (holding_copy_reg[1] == holding_copy_reg[2]);
  wire m13_w = (holding_copy_reg[1] == new_w);
  wire m23_w = (holding_copy_reg[2] == new_w);
  wire use0_w = m01_w || m02_w || m03_w;
  wire use1_w = m12_w || m13_w;
  wire match_w = use0_w || use1_w || m23_w;
  wire vote_ok_w = fourth_w && match_w;
  wire vote_bad_w = fourth_w && !match_w;
  assign pick_w = use0_w ? holding_copy_reg[0] : (use1_w ? holding_copy_reg[1] : holding_copy_reg[2]);
  assign segs_w.hi = rft_pkg::nibble_to_segment_table(rft_pkg::symbol_to_nibble_table(pick_w.hi));
  assign segs_w.lo = rft_pkg::nibble_to_segment_table(rft_pkg::symbol_to_nibble_table(pick_w.lo));
  assign display_segments = seg_out_reg;
  assign rx_accept = accept_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg <= '0;
      holding_copy_reg[0] <= '0;
      holding_copy_reg[1] <= '0;
      holding_copy_reg[2] <= '0;
      copy_idx_reg <= 2'h0;
      disp_reg <= '0;
      accept_reg <= 1'b0;
      seg_out_reg <= 16'h0000;
    end else begin
      if (post_w) rx_shift_reg <= '0;
      else if (sample_w) rx_shift_reg <= rx_next_w;
      if (post_w && !fourth_w) holding_copy_reg[copy_idx_reg] <= new_w;
      if (post_w) copy_idx_reg <= copy_idx_reg + 2'h1;
      if (vote_ok_w) disp_reg <= segs_w;
      accept_reg <= vote_ok_w;
      seg_out_reg <= disp_reg ^ {16{display_common_drive}};
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_history_shift_in: assert property (sample_history_reg[0] == $past(radio_rx_data, 3))
    else $error("history lags input wrongly");
  a_edge_restart_timer: assert property (edge_w |=> rx_run_reg && rx_cnt_reg == '0)
    else $error("edge did not restart timer");
  a_sample_into_shift: assert property (sample_w && !post_w |=> rx_shift_reg[FB-1] == $past(sample_history_reg[0]))
    else $error("sampled bit not shifted in");
  a_post_stores_copy: assert property (post_w && !fourth_w |=> rx_shift_reg == '0 &&
    holding_copy_reg[$past(copy_idx_reg)] == $past(new_w))
    else $error("postamble capture failed");
  a_vote_shows_digits: assert property (vote_ok_w |=> disp_reg == $past(segs_w) ##1
    seg_out_reg == ($past(disp_reg) ^ {16{$past(display_common_drive)}}))
    else $error("accepted payload not displayed");
  a_vote_reject_hold: assert property (vote_bad_w |=> $stable(disp_reg) && copy_idx_reg == 2'h0)
    else $error("rejected copies changed display");
  a_load_sets_gap: assert property (load_w |=> frame_gap_counter_reg == GP_W'(GAP_CYCLES) &&
    frame_repeat_counter_reg == $past(frame_repeat_counter_reg) + 3'h1)
    else $error("load spacing wrong");
  a_repeat_bounded: assert property (frame_repeat_counter_reg <= 3'(rft_pkg::COPIES))
    else $error("more than four loads");
  a_state_step: assert property (advance_w |=> current_state_index_reg == $past(current_state_index_reg) + 3'h1 &&
    frame_repeat_counter_reg == 3'h0)
    else $error("state index did not step");
  a_frame_latch: assert property (pop_w |=> tx_shift_reg == $past(frame_w) && tx_busy_reg)
    else $error("frame not latched");
  a_bit_hold_whole: assert property ($changed(radio_tx_data) |-> $past(tx_tick_w) || $past(pop_w))
    else $error("tx bit moved mid period");
  a_radio_modes_fixed: assert property (radio_tx_mode && !radio_rx_mode)
    else $error("radio mode outputs wrong");

  // ==========================================================
  // Sequencer checks
  a_state_hold: assert property (!advance_w |=> $stable(current_state_index_reg))
    else $error("state index moved without advance");

  a_repeat_hold: assert property (!advance_w && !load_w |=> $stable(frame_repeat_counter_reg))
    else $error("repeat count moved without load");

  a_gap_count_down: assert property (!advance_w && !load_w && !gap_done_w |=>
    frame_gap_counter_reg == $past(frame_gap_counter_reg) - 1'b1)
    else $error("gap counter did not count down");

  // ==========================================================
  // Serializer checks
  a_tx_idle_low: assert property (!tx_busy_reg |-> !radio_tx_data)
    else $error("tx line not low while idle");

  a_tx_bits_bounded: assert property (tx_bits_reg <= 6'(FB))
    else $error("more than 36 bits sent");

  a_frame_ends_idle: assert property (tx_tick_w && tx_last_w |=> !tx_busy_reg)
    else $error("serializer ran past last bit");

  a_tx_bits_step: assert property (tx_tick_w |=> tx_bits_reg == $past(tx_bits_reg) + 6'h01)
    else $error("bit count did not step");

  a_tx_count_step: assert property (tx_busy_reg && !tx_tick_w |=>
    tx_cnt_reg == $past(tx_cnt_reg) + 1'b1)
    else $error("bit timer did not count");

  a_tx_shift_step: assert property (tx_tick_w |=>
    tx_shift_reg == {1'b0, $past(tx_shift_reg[FB-1:1])})
    else $error("frame did not shift one bit");

  // ==========================================================
  // Receiver checks
  a_history_shifts: assert property (sample_history_reg[2:1] == $past(sample_history_reg[1:0]))
    else $error("history did not shift");

  a_idle_timer_hold: assert property (!rx_run_reg && !edge_w |=> rx_cnt_reg == '0)
    else $error("timer ran before first edge");

  a_counter_wraps: assert property (rx_run_reg && !edge_w && rx_wrap_w |=> rx_cnt_reg == '0)
    else $error("timer did not wrap");

  a_sample_count_step: assert property (rx_run_reg && !edge_w && !rx_wrap_w |=>
    rx_cnt_reg == $past(rx_cnt_reg) + 1'b1)
    else $error("timer did not count");

  a_copy_idx_step: assert property (post_w |=> copy_idx_reg == $past(copy_idx_reg) + 2'h1)
    else $error("copy index did not step");

  a_holding_hold: assert property (!post_w |=> $stable(holding_copy_reg[0]) &&
    $stable(holding_copy_reg[1]) && $stable(holding_copy_reg[2]))
    else $error("holding copy moved without postamble");

  a_disp_hold: assert property (!vote_ok_w |=> $stable(disp_reg))
    else $error("display latch moved without vote");

  a_accept_pulse: assert property (accept_reg |=> !accept_reg)
    else $error("accept longer than one cycle");

  a_segments_track: assert property (seg_out_reg ==
    ($past(disp_reg) ^ {16{$past(display_common_drive)}}))
    else $error("segments not following latch and common");

  c_frame_loaded: cover property (pop_w);
  c_vote_accepted: cover property (vote_ok_w);
  c_vote_rejected: cover property (vote_bad_w);
  c_buffer_full: cover property (!buf_in_ready_w);
  c_copy_stored: cover property (post_w && !fourth_w);
endmodule : rft_top
`default_nettype wire

/* test/rft_radio_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rft_radio_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Transmit line from the block and loopback delay select
  input wire logic tx_bit,
  input wire logic [2:0] lag,
  // Frame injection
  input wire logic inject_mode,
  input wire logic send,
  input wire logic [35:0] word,
  input wire logic [4:0] bitc,
  output logic busy,
  // Receive line into the block
  output logic rx_bit
);
  // ==========================================================
  // Loopback delay and frame sender
  logic [7:0] dly_reg;
  logic [35:0] sh_reg;
  int bit_cnt;
  int cyc_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_reg <= 8'h00;
      sh_reg <= 36'h0;
      bit_cnt <= 0;
      cyc_cnt <= 0;
      busy <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      dly_reg <= {dly_reg[6:0], tx_bit};
      if (!inject_mode) begin
        rx_bit <= dly_reg[lag];
      end else if (send && !busy) begin
        sh_reg <= word;
        busy <= 1'b1;
        bit_cnt <= 0;
        cyc_cnt <= 0;
        rx_bit <= word[0];
      end else if (busy) begin
        if (cyc_cnt == int'(bitc) - 1) begin
          cyc_cnt <= 0;
          if (bit_cnt == 35) begin
            busy <= 1'b0;
            rx_bit <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 1;
            rx_bit <= sh_reg[bit_cnt+1];
          end
        end else begin
          cyc_cnt <= cyc_cnt + 1;
        end
      end
    end
  end
endmodule : rft_radio_model
`default_nettype wire

/* test/rft_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rft_top_tb_top;
  // ==========================================================
  // Signals
  localparam int BITC = 16;
  localparam int COMC = 50;
  logic clk;
  logic rst_n;
  logic radio_rx_data;
  logic radio_tx_data;
  logic radio_tx_mode;
  logic radio_rx_mode;
  logic display_common_drive;
  logic [15:0] display_segments;
  logic rx_accept;
  logic [2:0] lag;
  logic inj_mode;
  logic inj_send;
  logic [35:0] inj_word;
  logic [4:0] inj_bitc;
  logic inj_busy;
  int err_total;
  int compares;
  int cyc;
  int acc_cnt;
  int com_age;
  logic com_last;
  logic acc_last;
  bit com_seen;
  logic [35:0] got;
  logic [15:0] disp_exp;
  logic [11:0] pl [4];
  int a;
  int b;
  // ==========================================================
  // Instances
  rft_top #(.BIT_CYCLES(BITC), .SAMPLE_CYCLES(12), .GAP_CYCLES(40), .DWELL_CYCLES(3000),
    .COM_CYCLES(COMC)) i_rft_top (.clk(clk), .rst_n(rst_n), .radio_rx_data(radio_rx_data),
    .radio_tx_data(radio_tx_data), .radio_tx_mode(radio_tx_mode), .radio_rx_mode(radio_rx_mode),
    .display_common_drive(display_common_drive), .display_segments(display_segments),
    .rx_accept(rx_accept));
  rft_radio_model i_rft_radio_model (.clk(clk), .rst_n(rst_n), .tx_bit(radio_tx_data), .lag(lag),
    .inject_mode(inj_mode), .send(inj_send), .word(inj_word), .bitc(inj_bitc), .busy(inj_busy),
    .rx_bit(radio_rx_data));
  // ==========================================================
  // Helpers
  function automatic logic [5:0] sym(input int n);
    return rft_pkg::SYMBOLS[n*6 +: 6];
  endfunction : sym
  function automatic logic [15:0] exp_seg(input int hi, input int lo);
    return {rft_pkg::SEGS[hi*8 +: 8], rft_pkg::SEGS[lo*8 +: 8]};
  endfunction : exp_seg
  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] seen);
    compares++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : chk
  task automatic finish_test;
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic grab_frame(output logic [35:0] f);
    int n;
    logic prev;
    f = 36'h0;
    n = 0;
    while (radio_tx_data !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    while (radio_tx_data !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    prev = 1'b1;
    for (int off = 0; off <= 552; off++) begin
      if (radio_tx_data !== prev) chk("tx edge offset", 36'h0, 36'(off % BITC));
      if (off % BITC == BITC / 2) f[off/BITC+1] = radio_tx_data;
      prev = radio_tx_data;
      @(negedge clk);
    end
  endtask : grab_frame
  task automatic wait_accept(input logic [15:0] exp);
    int n;
    n = 0;
    while (rx_accept !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("rx accept", 36'h1, 36'(rx_accept));
    repeat (2) @(negedge clk);
    while (com_age < 2) @(negedge clk);
    chk("display", 36'(exp), 36'(display_segments ^ {16{display_common_drive}}));
  endtask : wait_accept
  task automatic send_frame(input logic [11:0] pay);
    int n;
    n = 0;
    @(posedge clk);
    inj_word <= {rft_pkg::POSTAMBLE, pay, rft_pkg::PREAMBLE};
    inj_bitc <= 5'(BITC + $urandom_range(0, 1));
    inj_send <= 1'b1;
    while (inj_busy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    inj_send <= 1'b0;
    while (inj_busy !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("inject done", 36'h0, 36'(n >= 1000));
    repeat (3 * BITC) @(posedge clk);
  endtask : send_frame
  // ==========================================================
  // Clock, timeout and monitors
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      com_age++;
      if (display_common_drive !== com_last) begin
        if (com_seen) chk("common period", 36'(COMC), 36'(com_age));
        com_seen = 1'b1;
        com_age = 0;
      end
      if (rx_accept === 1'b1) begin
        acc_cnt++;
        if (acc_last === 1'b1) chk("accept width", 36'h0, 36'h1);
      end
    end
    com_last = display_common_drive;
    acc_last = rx_accept;
  end
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    lag = 3'h0;
    inj_mode = 1'b0;
    inj_send = 1'b0;
    inj_word = 36'h0;
    inj_bitc = 5'(BITC);
    err_total = 0;
    compares = 0;
    cyc = 0;
    acc_cnt = 0;
    com_age = 0;
    com_seen = 1'b0;
    void'($urandom(99627));
    repeat (10) @(negedge clk);
    chk("reset outputs", 36'h40000, 36'({radio_tx_mode, radio_tx_data, display_segments, rx_accept}));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    lag <= 3'($urandom_range(0, 7));
    @(negedge clk);
    chk("radio modes", 36'h2, 36'({radio_tx_mode, radio_rx_mode}));
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 4; r++) begin
        grab_frame(got);
        chk("tx frame", {rft_pkg::POSTAMBLE, sym(s), sym(s + 8), rft_pkg::PREAMBLE}, got);
      end
      wait_accept(exp_seg(s, s + 8));
    end
    @(posedge clk);
    inj_mode <= 1'b1;
    disp_exp = exp_seg(1, 9);
    a = $urandom_range(0, 15);
    b = $urandom_range(0, 15);
    for (int k = 0; k < 4; k++) pl[k] = {sym(a), sym((b + k) % 16)};
    for (int k = 0; k < 4; k++) send_frame(pl[k]);
    repeat (100) @(negedge clk);
    chk("no match accepts", 36'd2, 36'(acc_cnt));
    chk("display kept", 36'(disp_exp), 36'(display_segments ^ {16{display_common_drive}}));
    pl[1] = {sym((a + 1) % 16), sym(b)};
    pl[2] = {sym((a + 2) % 16), sym(b)};
    pl[3] = {sym(a), sym(b)};
    pl[0] = pl[3];
    for (int k = 0; k < 3; k++) send_frame(pl[k]);
    fork
      send_frame(pl[3]);
      wait_accept(exp_seg(a, b));
    join
    pl[2] = {6'h3f, sym(b)};
    pl[3] = pl[2];
    for (int k = 0; k < 3; k++) send_frame(pl[k]);
    fork
      send_frame(pl[3]);
      wait_accept(exp_seg(0, b));
    join
    chk("accept count", 36'd4, 36'(acc_cnt));
    finish_test();
  end
endmodule : rft_top_tb_top
`default_nettype wire
